/* ppm_pkg.sv */
package ppm_pkg;

	// Pump count and system clock
	localparam int unsigned PUMPS = 3;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned TICK_PERIOD_NS = 1000000000;
	localparam int unsigned TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [5:0] SEC_PER_MIN_LAST = 6'h3b;
	localparam logic [5:0] MIN_PER_HOUR_LAST = 6'h3b;

	// Register map, one block of four words per pump
	localparam logic [31:0] PUMP_STRIDE = 32'h10;
	localparam logic [3:0] OFS_DELAY = 4'h0;
	localparam logic [3:0] OFS_LIMIT = 4'h4;
	localparam logic [3:0] OFS_CTRL = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;

	// Field positions
	localparam int OC_DLY_POS = 0;
	localparam int UC_DLY_POS = 8;
	localparam int PF_DLY_POS = 16;
	localparam int RUN_LIM_POS = 0;
	localparam int SPM_LIM_POS = 16;
	localparam int SPH_LIM_POS = 24;
	localparam int RUN_EN_POS = 0;
	localparam int SPM_EN_POS = 1;
	localparam int SPH_EN_POS = 2;
	localparam int TCO_EN_POS = 3;
	localparam int TCO_LIM_POS = 8;
	localparam int ST_STOP_POS = 7;
	localparam int ST_TCO_CNT_POS = 8;
	localparam int ST_SPM_CNT_POS = 12;
	localparam int ST_SPH_CNT_POS = 16;

	// Alarm bit positions
	localparam int A_OC = 0;
	localparam int A_UC = 1;
	localparam int A_PF = 2;
	localparam int A_RUN = 3;
	localparam int A_SPM = 4;
	localparam int A_SPH = 5;
	localparam int A_TCO = 6;
	localparam int NALARM = 7;

	// Setting ranges and values after reset
	localparam logic [13:0] OC_DLY_MIN = 14'h5;
	localparam logic [13:0] OC_DLY_MAX = 14'hf;
	localparam logic [3:0] OC_DLY_RST = 4'h5;
	localparam logic [13:0] UPF_DLY_MIN = 14'h1;
	localparam logic [13:0] UPF_DLY_MAX = 14'h78;
	localparam logic [6:0] UPF_DLY_RST = 7'h3;
	localparam logic [13:0] RUN_LIM_MIN = 14'h1;
	localparam logic [13:0] RUN_LIM_MAX = 14'h270f;
	localparam logic [13:0] RUN_LIM_RST = 14'h5a0;
	localparam logic [13:0] SPM_LIM_MIN = 14'h1;
	localparam logic [13:0] SPM_LIM_MAX = 14'h9;
	localparam logic [3:0] SPM_LIM_RST = 4'h9;
	localparam logic [13:0] SPH_LIM_MIN = 14'h1;
	localparam logic [13:0] SPH_LIM_MAX = 14'h63;
	localparam logic [6:0] SPH_LIM_RST = 7'h6;
	localparam logic [13:0] TCO_LIM_MIN = 14'h1;
	localparam logic [13:0] TCO_LIM_MAX = 14'ha;
	localparam logic [3:0] TCO_LIM_RST = 4'ha;
	localparam logic RUN_EN_RST = 1'b0;
	localparam logic SPM_EN_RST = 1'b1;
	localparam logic SPH_EN_RST = 1'b0;
	localparam logic TCO_EN_RST = 1'b0;

endpackage

/* ppm_qual_timer.sv */
`timescale 1ns/1ps

// Qualifies a condition that must persist for more than delay ticks
module ppm_qual_timer #(
	parameter int WIDTH = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Condition and time base
	input wire logic cond,
	input wire logic tick,
	input wire logic [WIDTH-1:0] delay,
	// Result
	output logic expired
);

	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	// Restart on any break; saturate one past delay
	always_comb
	begin
		cnt_d = cnt_q;
		if (!cond)
			cnt_d = '0; // R20
		else if (tick && cnt_q <= delay)
			cnt_d = cnt_q + WIDTH'(1);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	// Counting past delay guarantees the full time despite tick phase
	assign expired = cond && (cnt_q > delay); // R2

	property p_restart;
		@(posedge clk) disable iff (!rst_n)
		!cond |=> (cnt_q == '0) && !expired;
	endproperty
	a_restart: assert property (p_restart) // R20
		else $error("qualification count did not restart");

endmodule

/* ppm_monitor.sv */
`timescale 1ns/1ps

// What this block does
// [R1] Overcurrent alarm and stop only after delay 5..15 s, default 5 s.
// [R2] A fault shorter than its delay never raises the alarm.
// [R3] Undercurrent alarm and stop after delay 1..120 s, default 3 s.
// [R4] Low power factor (dry running) alarm after delay 1..120 s, default 3.
// [R5] Continuous run alarm has an enable bit, reset value 0.
// [R6] Enabled, running longer than the limit stops pump and alarms.
// [R7] Continuous run limit in minutes 1..9999, default 1440.
// [R8] Run alarm inhibits pump until the pump button is pressed.
// [R9] Starts per minute alarm enable resets to 1.
// [R10] Starts in a minute above limit 1..9 (default 9) alarm and stop.
// [R11] Starts per minute alarm inhibits and clears at minute end.
// [R12] Starts per hour alarm has an enable bit, reset value 0.
// [R13] Starts in an hour above limit 1..99 (default 6) alarm and stop.
// [R14] Starts per hour alarm inhibits and clears at hour end.
// [R15] Thermal cutout count alarm has an enable bit, reset value 0.
// [R16] Cutout count above limit alarms; pump held until alarm reset.
// [R17] Cutout is normally closed; each opening counts one overheating.
// [R18] Every setting and monitor exists separately for each pump.
// [R19] Cutout events accumulate without time window; limit 1..10, default 10.
// [R20] All times count ticks derived from a one second tick (minutes for the run limit); breaks restart counting.
// [R21] Stop request stands while any alarm of that pump is set.
module ppm_monitor
	import ppm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = ppm_pkg::TICK_CYCLES_DFLT,
	parameter int unsigned NPUMP = ppm_pkg::PUMPS
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Per-pump sense inputs, asynchronous
	input wire logic [NPUMP-1:0] overcurrent,
	input wire logic [NPUMP-1:0] undercurrent,
	input wire logic [NPUMP-1:0] low_power_factor,
	input wire logic [NPUMP-1:0] pump_running,
	input wire logic [NPUMP-1:0] thermal_closed,
	input wire logic [NPUMP-1:0] reset_button,
	// Per-pump stop requests to the contactor logic
	output logic [NPUMP-1:0] pump_stop
);
	import ppm_pkg::*;

	localparam int NIN = 6 * NPUMP;

	// Synchroniser stages and edge history
	logic [NIN-1:0] pin_raw;
	logic [NIN-1:0] sync1_q;
	logic [NIN-1:0] sync2_q;
	logic [NIN-1:0] prev_q;
	logic [NPUMP-1:0] ovc_s, unc_s, lpf_s, run_s, thc_s, btn_s;
	logic [NPUMP-1:0] run_prev, thc_prev, btn_prev;
	logic [NPUMP-1:0] start_ev, tco_ev, btn_ev;

	assign pin_raw = {reset_button, thermal_closed, pump_running,
		low_power_factor, undercurrent, overcurrent};
	assign {btn_s, thc_s, run_s, lpf_s, unc_s, ovc_s} = sync2_q;
	assign {btn_prev, thc_prev, run_prev} = prev_q[NIN-1:3*NPUMP];
	assign start_ev = run_s & ~run_prev;
	// Contact is normally closed, so an opening is a falling edge
	assign tco_ev = ~thc_s & thc_prev; // R17
	assign btn_ev = btn_s & ~btn_prev;

	// Two flops per pin before any logic looks at it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end
		else
		begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Time base: second, minute and hour pulses, all one cycle wide
	logic [31:0] div_q, div_d;
	logic [5:0] sec_q, sec_d, min_q, min_d;
	logic sec_tick_q, sec_tick_d, min_tick_q, min_tick_d;
	logic hour_tick_q, hour_tick_d;

	always_comb
	begin
		div_d = div_q + 32'h1;
		sec_d = sec_q;
		min_d = min_q;
		sec_tick_d = 1'b0;
		min_tick_d = 1'b0;
		hour_tick_d = 1'b0;
		if (div_q >= TICK_CYCLES - 1)
		begin
			div_d = '0;
			sec_tick_d = 1'b1; // R20
			sec_d = sec_q + 6'h1;
			if (sec_q == SEC_PER_MIN_LAST)
			begin
				sec_d = '0;
				min_tick_d = 1'b1;
				min_d = min_q + 6'h1;
				if (min_q == MIN_PER_HOUR_LAST)
				begin
					min_d = '0;
					hour_tick_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_q <= '0;
			sec_q <= '0;
			min_q <= '0;
			sec_tick_q <= 1'b0;
			min_tick_q <= 1'b0;
			hour_tick_q <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			sec_q <= sec_d;
			min_q <= min_d;
			sec_tick_q <= sec_tick_d;
			min_tick_q <= min_tick_d;
			hour_tick_q <= hour_tick_d;
		end
	end

	// Bus slave: writes take no wait, reads one wait state
	logic capture;
	logic wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
	logic [31:0] addr_q, addr_d, hrdata_d, rd_mux;
	logic hreadyout_d;
	logic [1:0] pidx;
	logic [3:0] ofs;
	logic mapped;

	assign capture = hsel && htrans[1] && hready;
	assign pidx = addr_q[5:4];
	assign ofs = addr_q[3:0];
	assign mapped = (addr_q[31:6] == '0) && (32'(pidx) < NPUMP);

	always_comb
	begin
		wr_pend_d = capture && hwrite;
		rd_pend_d = capture && !hwrite;
		addr_d = capture ? haddr : addr_q;
		// Read data sampled a cycle late so a preceding write is seen
		hreadyout_d = !(capture && !hwrite);
		hrdata_d = rd_pend_q ? rd_mux : hrdata;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= '0;
		end
		else
		begin
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			addr_q <= addr_d;
			hreadyout <= hreadyout_d;
			hresp <= 1'b0;
			hrdata <= hrdata_d;
		end
	end

	// Settings per pump
	logic [3:0] ocd_q [NPUMP], ocd_d [NPUMP];
	logic [6:0] ucd_q [NPUMP], ucd_d [NPUMP];
	logic [6:0] pfd_q [NPUMP], pfd_d [NPUMP];
	logic [13:0] rlim_q [NPUMP], rlim_d [NPUMP];
	logic [3:0] spml_q [NPUMP], spml_d [NPUMP];
	logic [6:0] sphl_q [NPUMP], sphl_d [NPUMP];
	logic [3:0] tcol_q [NPUMP], tcol_d [NPUMP];
	logic [NPUMP-1:0] run_en_q, run_en_d, spm_en_q, spm_en_d;
	logic [NPUMP-1:0] sph_en_q, sph_en_d, tco_en_q, tco_en_d;

	// Out-of-range values are pulled into the settable range
	function automatic logic [13:0] clampv(input logic [13:0] v,
		input logic [13:0] lo, input logic [13:0] hi);
		clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	always_comb
	begin
		for (int p = 0; p < NPUMP; p++)
		begin
			ocd_d[p] = ocd_q[p];
			ucd_d[p] = ucd_q[p];
			pfd_d[p] = pfd_q[p];
			rlim_d[p] = rlim_q[p];
			spml_d[p] = spml_q[p];
			sphl_d[p] = sphl_q[p];
			tcol_d[p] = tcol_q[p];
			run_en_d[p] = run_en_q[p];
			spm_en_d[p] = spm_en_q[p];
			sph_en_d[p] = sph_en_q[p];
			tco_en_d[p] = tco_en_q[p];
			if (wr_pend_q && hready && mapped && 32'(pidx) == p) // R18
			begin
				if (ofs == OFS_DELAY)
				begin
					ocd_d[p] = 4'(clampv({6'h0, hwdata[OC_DLY_POS+:8]},
						OC_DLY_MIN, OC_DLY_MAX)); // R1
					ucd_d[p] = 7'(clampv({6'h0, hwdata[UC_DLY_POS+:8]},
						UPF_DLY_MIN, UPF_DLY_MAX)); // R3
					pfd_d[p] = 7'(clampv({6'h0, hwdata[PF_DLY_POS+:8]},
						UPF_DLY_MIN, UPF_DLY_MAX)); // R4
				end
				if (ofs == OFS_LIMIT)
				begin
					rlim_d[p] = clampv(hwdata[RUN_LIM_POS+:14],
						RUN_LIM_MIN, RUN_LIM_MAX); // R7
					spml_d[p] = 4'(clampv({10'h0, hwdata[SPM_LIM_POS+:4]},
						SPM_LIM_MIN, SPM_LIM_MAX)); // R10
					sphl_d[p] = 7'(clampv({7'h0, hwdata[SPH_LIM_POS+:7]},
						SPH_LIM_MIN, SPH_LIM_MAX)); // R13
				end
				if (ofs == OFS_CTRL)
				begin
					run_en_d[p] = hwdata[RUN_EN_POS]; // R5
					spm_en_d[p] = hwdata[SPM_EN_POS]; // R9
					sph_en_d[p] = hwdata[SPH_EN_POS]; // R12
					tco_en_d[p] = hwdata[TCO_EN_POS]; // R15
					tcol_d[p] = 4'(clampv({10'h0, hwdata[TCO_LIM_POS+:4]},
						TCO_LIM_MIN, TCO_LIM_MAX)); // R19
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int p = 0; p < NPUMP; p++)
			begin
				ocd_q[p] <= OC_DLY_RST;
				ucd_q[p] <= UPF_DLY_RST;
				pfd_q[p] <= UPF_DLY_RST;
				rlim_q[p] <= RUN_LIM_RST;
				spml_q[p] <= SPM_LIM_RST;
				sphl_q[p] <= SPH_LIM_RST;
				tcol_q[p] <= TCO_LIM_RST;
			end
			run_en_q <= {NPUMP{RUN_EN_RST}};
			spm_en_q <= {NPUMP{SPM_EN_RST}};
			sph_en_q <= {NPUMP{SPH_EN_RST}};
			tco_en_q <= {NPUMP{TCO_EN_RST}};
		end
		else
		begin
			ocd_q <= ocd_d;
			ucd_q <= ucd_d;
			pfd_q <= pfd_d;
			rlim_q <= rlim_d;
			spml_q <= spml_d;
			sphl_q <= sphl_d;
			tcol_q <= tcol_d;
			run_en_q <= run_en_d;
			spm_en_q <= spm_en_d;
			sph_en_q <= sph_en_d;
			tco_en_q <= tco_en_d;
		end
	end

	// Qualification timers, four per pump
	logic [NPUMP-1:0] exp_oc, exp_uc, exp_pf, exp_run, run_cond;

	for (genvar g = 0; g < NPUMP; g++)
	begin : g_qual
		assign run_cond[g] = run_s[g] && run_en_q[g];
		ppm_qual_timer #(.WIDTH(7)) u_oc (.clk(hclk), .rst_n(hresetn),
			.cond(ovc_s[g]), .tick(sec_tick_q), .delay({3'h0, ocd_q[g]}),
			.expired(exp_oc[g])); // R1
		ppm_qual_timer #(.WIDTH(7)) u_uc (.clk(hclk), .rst_n(hresetn),
			.cond(unc_s[g]), .tick(sec_tick_q), .delay(ucd_q[g]),
			.expired(exp_uc[g])); // R3
		ppm_qual_timer #(.WIDTH(7)) u_pf (.clk(hclk), .rst_n(hresetn),
			.cond(lpf_s[g]), .tick(sec_tick_q), .delay(pfd_q[g]),
			.expired(exp_pf[g])); // R4
		// Minute tick; a disabled or stopped pump restarts the count
		ppm_qual_timer #(.WIDTH(14)) u_run (.clk(hclk), .rst_n(hresetn),
			.cond(run_cond[g]), .tick(min_tick_q), .delay(rlim_q[g]),
			.expired(exp_run[g])); // R6
	end

	// Alarms, start and cutout counters; sets win over clears
	logic [NALARM-1:0] alm_q [NPUMP], alm_d [NPUMP];
	logic [3:0] spmc_q [NPUMP], spmc_d [NPUMP];
	logic [6:0] sphc_q [NPUMP], sphc_d [NPUMP];
	logic [3:0] tcoc_q [NPUMP], tcoc_d [NPUMP];
	logic [NPUMP-1:0] stop_d;

	always_comb
	begin
		for (int p = 0; p < NPUMP; p++)
		begin
			alm_d[p] = alm_q[p];
			spmc_d[p] = spmc_q[p];
			sphc_d[p] = sphc_q[p];
			tcoc_d[p] = tcoc_q[p];
			// Operator button only acts while the pump is in alarm
			if (btn_ev[p] && (|alm_q[p]))
			begin
				alm_d[p][A_OC] = 1'b0;
				alm_d[p][A_UC] = 1'b0;
				alm_d[p][A_PF] = 1'b0;
				alm_d[p][A_RUN] = 1'b0; // R8
				alm_d[p][A_TCO] = 1'b0; // R16
				tcoc_d[p] = '0;
			end
			if (min_tick_q)
			begin
				alm_d[p][A_SPM] = 1'b0; // R11
				spmc_d[p] = '0;
			end
			if (hour_tick_q)
			begin
				alm_d[p][A_SPH] = 1'b0; // R14
				sphc_d[p] = '0;
			end
			if (start_ev[p] && spmc_d[p] != 4'hf)
				spmc_d[p] = spmc_d[p] + 4'h1;
			if (start_ev[p] && sphc_d[p] != 7'h7f)
				sphc_d[p] = sphc_d[p] + 7'h1;
			// No time window: events add up for as long as it takes
			if (tco_ev[p] && tcoc_d[p] != 4'hf)
				tcoc_d[p] = tcoc_d[p] + 4'h1; // R19
			if (exp_oc[p])
				alm_d[p][A_OC] = 1'b1; // R1
			if (exp_uc[p])
				alm_d[p][A_UC] = 1'b1; // R3
			if (exp_pf[p])
				alm_d[p][A_PF] = 1'b1; // R4
			if (exp_run[p])
				alm_d[p][A_RUN] = 1'b1; // R6
			if (spm_en_q[p] && spmc_d[p] > spml_q[p])
				alm_d[p][A_SPM] = 1'b1; // R10
			if (sph_en_q[p] && sphc_d[p] > sphl_q[p])
				alm_d[p][A_SPH] = 1'b1; // R13
			if (tco_en_q[p] && tcoc_d[p] > tcol_q[p])
				alm_d[p][A_TCO] = 1'b1; // R16
			stop_d[p] = |alm_d[p]; // R21
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int p = 0; p < NPUMP; p++)
			begin
				alm_q[p] <= '0;
				spmc_q[p] <= '0;
				sphc_q[p] <= '0;
				tcoc_q[p] <= '0;
			end
			pump_stop <= '0;
		end
		else
		begin
			alm_q <= alm_d;
			spmc_q <= spmc_d;
			sphc_q <= sphc_d;
			tcoc_q <= tcoc_d;
			pump_stop <= stop_d;
		end
	end

	// Read mux; unmapped words read as zero
	always_comb
	begin
		rd_mux = '0;
		for (int p = 0; p < NPUMP; p++)
		begin
			if (mapped && 32'(pidx) == p)
			begin
				case (ofs)
					OFS_DELAY: rd_mux = {8'h0, 1'b0, pfd_q[p], 1'b0,
						ucd_q[p], 4'h0, ocd_q[p]};
					OFS_LIMIT: rd_mux = {1'b0, sphl_q[p], 4'h0, spml_q[p],
						2'h0, rlim_q[p]};
					OFS_CTRL: rd_mux = {20'h0, tcol_q[p], 4'h0, tco_en_q[p],
						sph_en_q[p], spm_en_q[p], run_en_q[p]};
					OFS_STATUS: rd_mux = {9'h0, sphc_q[p], spmc_q[p],
						tcoc_q[p], pump_stop[p], alm_q[p]};
					default: rd_mux = '0;
				endcase
			end
		end
	end

	// Checks per pump
	for (genvar g = 0; g < NPUMP; g++)
	begin : g_chk
		property p_stop_any;
			@(posedge hclk) disable iff (!hresetn)
			pump_stop[g] == (|alm_q[g]);
		endproperty
		a_stop_any: assert property (p_stop_any) // R21
			else $error("stop request disagrees with alarms");

		property p_oc_cause;
			@(posedge hclk) disable iff (!hresetn)
			$rose(alm_q[g][A_OC]) |-> $past(ovc_s[g]);
		endproperty
		a_oc_cause: assert property (p_oc_cause) // R2
			else $error("overcurrent alarm without condition");

		property p_run_en;
			@(posedge hclk) disable iff (!hresetn)
			$rose(alm_q[g][A_RUN]) |-> $past(run_en_q[g]);
		endproperty
		a_run_en: assert property (p_run_en) // R5
			else $error("run alarm while disabled");

		property p_run_hold;
			@(posedge hclk) disable iff (!hresetn)
			alm_q[g][A_RUN] && !btn_ev[g] |=> alm_q[g][A_RUN];
		endproperty
		a_run_hold: assert property (p_run_hold) // R8
			else $error("run alarm cleared without button");

		property p_spm_clear;
			@(posedge hclk) disable iff (!hresetn)
			min_tick_q |=> !alm_q[g][A_SPM] && spmc_q[g] <= 4'h1;
		endproperty
		a_spm_clear: assert property (p_spm_clear) // R11
			else $error("starts per minute alarm kept past minute");

		property p_sph_clear;
			@(posedge hclk) disable iff (!hresetn)
			hour_tick_q && sphl_q[g] != '0 |=> !alm_q[g][A_SPH];
		endproperty
		a_sph_clear: assert property (p_sph_clear) // R14
			else $error("starts per hour alarm kept past hour");

		property p_tco_hold;
			@(posedge hclk) disable iff (!hresetn)
			alm_q[g][A_TCO] && !btn_ev[g] |=> alm_q[g][A_TCO];
		endproperty
		a_tco_hold: assert property (p_tco_hold) // R16
			else $error("cutout alarm cleared without button");

		property p_tco_count;
			@(posedge hclk) disable iff (!hresetn)
			tco_ev[g] && !btn_ev[g] && tcoc_q[g] != 4'hf
				|=> tcoc_q[g] == $past(tcoc_q[g]) + 4'h1;
		endproperty
		a_tco_count: assert property (p_tco_count) // R17
			else $error("cutout opening not counted");
	end

	property p_read_wait;
		@(posedge hclk) disable iff (!hresetn)
		capture && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) // R18
		else $error("read wait state wrong");

endmodule

/* ppm_pump_model.sv */
`timescale 1ns/1ps

// Far side of one panel: contactors, current sensing, thermal contacts
module ppm_pump_model
	import ppm_pkg::*;
#(
	parameter int COOL_CYCLES = 30
) (
	// Clock
	input wire logic clk,
	// Stop requests from the monitor
	input wire logic [ppm_pkg::PUMPS-1:0] pump_stop,
	// Sensed conditions per pump
	output logic [ppm_pkg::PUMPS-1:0] overcurrent,
	output logic [ppm_pkg::PUMPS-1:0] undercurrent,
	output logic [ppm_pkg::PUMPS-1:0] low_power_factor,
	output logic [ppm_pkg::PUMPS-1:0] pump_running,
	output logic [ppm_pkg::PUMPS-1:0] thermal_closed
);
	// Idle pumps, healthy motors, cutout contacts closed
	initial
	begin
		overcurrent = '0;
		undercurrent = '0;
		low_power_factor = '0;
		pump_running = '0;
		thermal_closed = '1;
	end

	// Contactor opens as soon as a stop is requested
	always @(posedge clk)
	begin
		if (|(pump_running & pump_stop))
			pump_running <= pump_running & ~pump_stop;
	end

	// A start: contactor drops, then closes unless a stop is pending
	task automatic start(input int p);
		@(posedge clk);
		pump_running[p] <= 1'b0;
		repeat (4) @(posedge clk);
		pump_running[p] <= ~pump_stop[p];
	endtask

	// Sets or clears a fault: 0 over, 1 under, 2 low power factor
	task automatic fault(input int k, input int p, input logic v);
		@(posedge clk);
		case (k)
			0: overcurrent[p] <= v;
			1: undercurrent[p] <= v;
			default: low_power_factor[p] <= v;
		endcase
	endtask

	// Overheating opens the contact; it recloses by itself once cooled
	task automatic trip(input int p);
		@(posedge clk);
		thermal_closed[p] <= 1'b0;
		repeat (COOL_CYCLES) @(posedge clk);
		thermal_closed[p] <= 1'b1;
	endtask
endmodule

/* pump_protection_monitor_tb.sv */
`timescale 1ns/1ps

module pump_protection_monitor_tb;
	import ppm_pkg::*;

	logic hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0] htrans;
	logic [2:0] hsize, reset_button, pump_stop;
	logic [2:0] oc, uc, lpf, run, tco;
	logic hready, hreadyout, hresp;
	int failures, n_checks;

	// Short second tick keeps minute windows within the run
	ppm_monitor #(.TICK_CYCLES(10)) DUT (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.overcurrent(oc), .undercurrent(uc), .low_power_factor(lpf),
		.pump_running(run), .thermal_closed(tco),
		.reset_button(reset_button), .pump_stop(pump_stop));
	ppm_pump_model PM (.clk(hclk), .pump_stop(pump_stop),
		.overcurrent(oc), .undercurrent(uc), .low_power_factor(lpf),
		.pump_running(run), .thermal_closed(tco));
	assign hready = hreadyout;

	// Clock
	initial hclk = 1'b0;
	always #50 hclk = ~hclk;

	// One single transfer; waits on hready in both phases
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= a;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		logic [31:0] x;
		ahb(1'b1, a, v, x);
	endtask

	task automatic rchk(input string nm, input logic [31:0] a,
		input logic [31:0] e, input logic [31:0] m);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		chk(nm, e, x & m);
	endtask

	task automatic stp(input logic [2:0] e);
		chk("pump_stop", {29'h0, e}, {29'h0, pump_stop});
	endtask

	// Operator presses one pump's button
	task automatic press(input int p);
		@(posedge hclk);
		reset_button[p] <= 1'b1;
		repeat (5) @(posedge hclk);
		reset_button[p] <= 1'b0;
		repeat (10) @(posedge hclk);
	endtask

	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Whole run needs well under this many cycles
	initial
	begin
		#(60000 * 100);
		failures++;
		$display("Error watchdog expected finish seen timeout");
		print_verdict();
	end

	// Main sequence
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		reset_button = 3'b000;
		failures = 0;
		n_checks = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;

		// Settings after reset, clamping, unmapped place
		rchk("delay0", 32'h0, 32'h00030305, '1);
		rchk("limit0", 32'h4, 32'h060905a0, '1);
		rchk("ctrl0", 32'h8, 32'h00000a02, '1);
		rchk("unmapped", 32'h40, 32'h0, '1);
		chk("hresp", 32'h0, {31'h0, hresp});
		wr(32'h20, 32'h0005c802);
		rchk("delay2", 32'h20, 32'h00057805, '1);
		rchk("delay0 kept", 32'h0, 32'h00030305, '1);
		// Short delays again so every fault qualifies within the wait
		wr(32'h20, 32'h00050305);
		rchk("delay2 short", 32'h20, 32'h00050305, '1);
		$display("Test settings done");

		// A fault shorter than its delay stays silent
		PM.fault(0, 0, 1'b1);
		repeat (30) @(posedge hclk);
		PM.fault(0, 0, 1'b0);
		repeat (40) @(posedge hclk);
		stp(3'b000);
		$display("Test short fault done");

		// Every qualified fault kind on every pump, then operator reset
		for (int k = 0; k < 3; k++)
			for (int i = 0; i < 3; i++)
			begin
				PM.fault(k, i, 1'b1);
				repeat (80) @(posedge hclk);
				stp(3'(1 << i));
				rchk("status", 32'hc + 32'(i) * 32'h10,
					32'h80 | 32'(1 << k), 32'hff);
				PM.fault(k, i, 1'b0);
				press(i);
				stp(3'b000);
			end
		$display("Test qualified faults done");

		// Starts per minute on pump 2 with limit 1
		wr(32'h24, 32'h060105a0);
		PM.start(2);
		// Let the first start reach the count, so polling waits for the minute end
		repeat (5) @(posedge hclk);
		do
			ahb(1'b0, 32'h2c, 32'h0, d);
		while (d[15:12] !== 4'h0);
		PM.start(2);
		PM.start(2);
		repeat (5) @(posedge hclk);
		stp(3'b100);
		rchk("spm alarm", 32'h2c, 32'h10, 32'h10);
		do
			ahb(1'b0, 32'h2c, 32'h0, d);
		while (d[4] !== 1'b0);
		repeat (2) @(posedge hclk);
		stp(3'b000);
		$display("Test starts per minute done");

		// Cutout count on pump 1 with limit 1
		wr(32'h18, 32'h0000010a);
		PM.trip(1);
		repeat (5) @(posedge hclk);
		stp(3'b000);
		rchk("tco count", 32'h1c, 32'h100, 32'hf00);
		PM.trip(1);
		repeat (5) @(posedge hclk);
		stp(3'b010);
		repeat (100) @(posedge hclk);
		stp(3'b010);
		press(1);
		stp(3'b000);
		$display("Test cutout count done");

		// Continuous run limit of one minute on pump 0
		wr(32'h4, 32'h06090001);
		wr(32'h8, 32'h00000a03);
		PM.start(0);
		repeat (1300) @(posedge hclk);
		stp(3'b001);
		rchk("run alarm", 32'hc, 32'h88, 32'hff);
		repeat (100) @(posedge hclk);
		stp(3'b001);
		press(0);
		stp(3'b000);
		$display("Test run limit done");

		// Starts per hour on pump 1 with limit 1, cleared at hour end
		wr(32'h14, 32'h010905a0);
		wr(32'h18, 32'h00000a06);
		PM.start(1);
		PM.start(1);
		repeat (5) @(posedge hclk);
		stp(3'b010);
		rchk("sph alarm", 32'h1c, 32'h20, 32'h20);
		do
			ahb(1'b0, 32'h1c, 32'h0, d);
		while (d[5] !== 1'b0);
		repeat (2) @(posedge hclk);
		stp(3'b000);
		$display("Test starts per hour done");

		// Reset in mid-run brings every setting back
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		stp(3'b000);
		rchk("ctrl1 after reset", 32'h18, 32'h00000a02, '1);
		rchk("limit0 after reset", 32'h4, 32'h060905a0, '1);
		$display("Test mid-run reset done");
		print_verdict();
	end
endmodule
